// [hw/asfi_pkg.sv]
// Overview of operation
// - Self-clocking: device drives serial clock, read sync
// - Serial clock derived from master clock
// - Self-clocking: finished result is sent without host polling
// - Every frame carries exactly sixteen bits
// - Tied syncs: control shifts in during read
// - External clocking: access allowed during conversion
// - Bit decisions on falling master clock edges
// - Output bits launched on rising serial clock
// - Command latched on sixth serial clock edge
package asfi_pkg;
    // Serial word and result layout
    localparam int unsigned WORD_BITS     = 16;
    localparam int unsigned RES_BITS      = 12;
    localparam int unsigned CHAN_BITS     = 3;
    localparam logic [4:0]  BIT_CNT_MAX   = 5'h10;
    // Control word fields, first bits shifted in
    localparam int unsigned CTRL_BITS     = 5;
    localparam int unsigned CTRL_CHAN_MSB = 4;
    localparam int unsigned CTRL_CHAN_LSB = 2;
    localparam int unsigned CTRL_CONV_BIT = 1;
    localparam int unsigned CTRL_STBY_BIT = 0;
    localparam logic [4:0]  CTRL_RST      = 5'h00;
    // Sixth serial edge of a write frame is count index five
    localparam logic [4:0]  CMD_EDGE_IDX  = 5'h05;
    // Result path
    localparam logic [3:0]  SAR_TOP       = 4'hb;
    localparam logic [11:0] SAR_FIRST     = 12'h800;
    localparam int unsigned FIFO_DEPTH    = 16;
    // Self-clocking burst shape: lead and trail in serial clock periods, half period in master clocks
    localparam logic [4:0]  LEAD_PERIODS  = 5'h02;
    localparam logic [4:0]  TRAIL_PERIODS = 5'h02;
    localparam int unsigned SCLK_HALF_CYC = 1;
    // Burst sequencer, Gray along idle-lead-frame-trail
    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_LEAD  = 2'b01,
        BURST_FRAME = 2'b11,
        BURST_TRAIL = 2'b10
    } asfi_burst_e;
endpackage

// [hw/asfi_fifo.sv]
`timescale 1ns/1ps
module asfi_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Word storage
    logic [AW:0]      wr_ptr_q;        // Write pointer with wrap bit
    logic [AW:0]      wr_ptr_d;
    logic [AW:0]      rd_ptr_q;        // Read pointer with wrap bit
    logic [AW:0]      rd_ptr_d;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit
    always_comb begin
        in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                      (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
        out_valid = (wr_ptr_q != rd_ptr_q);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_ptr_d  = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d  = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        out_data  = mem_q[rd_ptr_q[AW-1:0]];
    end

    // Pointers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
        end
    end

    // Storage needs no reset, guarded by the pointers
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// [hw/asfi_top.sv]
`timescale 1ns/1ps
module asfi_top
    import asfi_pkg::*;
#(
    parameter int unsigned SCLK_HALF = asfi_pkg::SCLK_HALF_CYC,
    parameter int unsigned DEPTH     = asfi_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        self_clock_mode,
    input  wire logic        conversion_start_n,
    input  wire logic        cmp_hi,
    input  wire logic        clk_link,
    input  wire logic        read_frame_sync_n_i,
    input  wire logic        write_frame_sync_n,
    input  wire logic        data_in,
    output logic             sclk_o,
    output logic             sclk_oe,
    output logic             read_frame_sync_n_o,
    output logic             read_frame_sync_n_oe,
    output logic             data_out_o,
    output logic             data_out_oe,
    output logic [11:0]      trial_code,
    output logic [2:0]       mux_chan,
    output logic             standby,
    output logic             conv_busy
);
    import asfi_pkg::*;

    localparam logic [7:0] DIV_LAST  = 8'(SCLK_HALF - 1);
    localparam int         FRAME_CYC = WORD_BITS * 2 * SCLK_HALF;

    // Pin synchronisers into the system domain
    logic       mode_s1, mode_s2;      // Clocking mode strap
    logic       cs_s1, cs_s2, cs_s3;   // Hardware start, third for edge
    logic       rfs_s1, rfs_s2;        // Read frame level for idle test
    logic       tgl_s1, tgl_s2, tgl_s3;// Control write event toggle
    logic       ctrl_tgl_q;            // Link-side write event toggle

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {mode_s1, mode_s2}      <= 2'h0;
            {cs_s1, cs_s2, cs_s3}   <= 3'h7;
            {rfs_s1, rfs_s2}        <= 2'h3;
            {tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
        end else begin
            {mode_s1, mode_s2}      <= {self_clock_mode, mode_s1};
            {cs_s1, cs_s2, cs_s3}   <= {conversion_start_n, cs_s1, cs_s2};
            {rfs_s1, rfs_s2}        <= {read_frame_sync_n_i, rfs_s1};
            {tgl_s1, tgl_s2, tgl_s3} <= {ctrl_tgl_q, tgl_s1, tgl_s2};
        end
    end

    // Control word as latched at the link end
    logic [4:0] ctrl_lk_q;
    logic       ctrl_evt;
    logic       hw_start;
    assign ctrl_evt = tgl_s2 ^ tgl_s3;
    assign hw_start = cs_s2 && !cs_s3;

    // Control register in system domain, start request
    logic [2:0] mux_chan_q, mux_chan_d;
    logic       standby_q, standby_d;
    logic       start_pend_q, start_pend_d;
    logic       res_valid_q, res_valid_d;
    logic [15:0] res_word_q, res_word_d;
    logic       fifo_in_ready;
    logic       conv_busy_q;
    logic       done_q;
    logic [11:0] sar_q;
    logic [2:0] conv_chan_q;

    // Link word is stable while the toggle travels, so it is read directly
    always_comb begin
        mux_chan_d   = mux_chan_q;
        standby_d    = standby_q;
        start_pend_d = start_pend_q;
        res_valid_d  = res_valid_q;
        res_word_d   = res_word_q;
        if (ctrl_evt) begin
            mux_chan_d = ctrl_lk_q[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
            standby_d  = ctrl_lk_q[CTRL_STBY_BIT];
        end
        // Starts are refused while busy, in standby or holding a result
        if ((hw_start || (ctrl_evt && ctrl_lk_q[CTRL_CONV_BIT])) &&
            !conv_busy_q && !res_valid_q && !standby_q) begin
            start_pend_d = 1'b1;
        end else if (conv_busy_q) begin
            start_pend_d = 1'b0;
        end
        // Result waits here until the buffer has room
        if (done_q) begin
            res_valid_d = 1'b1;
            res_word_d  = {1'b0, conv_chan_q, sar_q};
        end else if (res_valid_q && fifo_in_ready) begin
            res_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mux_chan_q   <= CTRL_RST[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
            standby_q    <= CTRL_RST[CTRL_STBY_BIT];
            start_pend_q <= 1'b0;
            res_valid_q  <= 1'b0;
            res_word_q   <= 16'h0000;
        end else begin
            mux_chan_q   <= mux_chan_d;
            standby_q    <= standby_d;
            start_pend_q <= start_pend_d;
            res_valid_q  <= res_valid_d;
            res_word_q   <= res_word_d;
        end
    end

    // Successive approximation on the falling master clock edge
    logic [3:0]  step_q, step_d;
    logic [11:0] sar_d;
    logic        conv_busy_d;
    logic        done_d;
    logic [2:0]  conv_chan_d;

    always_comb begin
        step_d      = step_q;
        sar_d       = sar_q;
        conv_busy_d = conv_busy_q;
        conv_chan_d = conv_chan_q;
        done_d      = 1'b0;
        if (!conv_busy_q && start_pend_q) begin
            conv_busy_d = 1'b1;
            step_d      = SAR_TOP;
            sar_d       = SAR_FIRST;
            conv_chan_d = mux_chan_q;
        end else if (conv_busy_q) begin
            // Keep the trial bit only if the input is at or above it
            sar_d[step_q] = cmp_hi;
            if (step_q != 4'h0) begin
                sar_d[step_q - 4'h1] = 1'b1;
                step_d               = step_q - 4'h1;
            end else begin
                conv_busy_d = 1'b0;
                done_d      = 1'b1;
            end
        end
    end

    always_ff @(negedge clk_sys) begin
        if (srst) begin
            step_q      <= 4'h0;
            sar_q       <= 12'h000;
            conv_busy_q <= 1'b0;
            conv_chan_q <= 3'h0;
            done_q      <= 1'b0;
        end else begin
            step_q      <= step_d;
            sar_q       <= sar_d;
            conv_busy_q <= conv_busy_d;
            conv_chan_q <= conv_chan_d;
            done_q      <= done_d;
        end
    end

    // Results queue between converter and serial port
    logic        fifo_out_valid;
    logic        fifo_pop;
    logic [15:0] fifo_out_data;

    asfi_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (res_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (res_word_q),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // Output register and self-clocking burst sequencer
    asfi_burst_e burst_q, burst_d;
    logic [7:0]  div_cnt_q, div_cnt_d;
    logic [4:0]  per_cnt_q, per_cnt_d;
    logic        sclk_q, sclk_d;
    logic        rfs_o_q, rfs_o_d;
    logic        sclk_oe_q, rfs_oe_q;
    logic [15:0] tx_word_q, tx_word_d;
    logic        tick;
    logic        fall;

    always_comb begin
        burst_d   = burst_q;
        div_cnt_d = div_cnt_q;
        per_cnt_d = per_cnt_q;
        sclk_d    = sclk_q;
        rfs_o_d   = rfs_o_q;
        tx_word_d = tx_word_q;
        fifo_pop  = 1'b0;
        tick      = (div_cnt_q == DIV_LAST);
        fall      = tick && sclk_q;
        if (burst_q != BURST_IDLE) begin
            div_cnt_d = tick ? 8'h00 : div_cnt_q + 8'h01;
            sclk_d    = tick ? !sclk_q : sclk_q;
        end
        case (burst_q)
            BURST_IDLE: begin
                sclk_d    = 1'b0;
                div_cnt_d = 8'h00;
                per_cnt_d = 5'h00;
                rfs_o_d   = 1'b1;
                if (fifo_out_valid && mode_s2) begin
                    // No polling: a queued result starts a burst at once
                    fifo_pop  = 1'b1;
                    tx_word_d = fifo_out_data;
                    burst_d   = BURST_LEAD;
                end else if (fifo_out_valid && rfs_s2) begin
                    // Host-clocked: refresh output word only between frames
                    fifo_pop  = 1'b1;
                    tx_word_d = fifo_out_data;
                end
            end
            BURST_LEAD: begin
                // Idle edges let the link end clear its counters
                if (fall) begin
                    per_cnt_d = per_cnt_q + 5'h01;
                    if (per_cnt_q == LEAD_PERIODS - 5'h01) begin
                        burst_d   = BURST_FRAME;
                        per_cnt_d = 5'h00;
                        rfs_o_d   = 1'b0;
                    end
                end
            end
            BURST_FRAME: begin
                if (fall) begin
                    per_cnt_d = per_cnt_q + 5'h01;
                    if (per_cnt_q == BIT_CNT_MAX - 5'h01) begin
                        burst_d   = BURST_TRAIL;
                        per_cnt_d = 5'h00;
                        rfs_o_d   = 1'b1;
                    end
                end
            end
            BURST_TRAIL: begin
                if (fall) begin
                    per_cnt_d = per_cnt_q + 5'h01;
                    if (per_cnt_q == TRAIL_PERIODS - 5'h01) begin
                        burst_d = BURST_IDLE;
                    end
                end
            end
            default: begin
                burst_d = BURST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            burst_q   <= BURST_IDLE;
            div_cnt_q <= 8'h00;
            per_cnt_q <= 5'h00;
            sclk_q    <= 1'b0;
            rfs_o_q   <= 1'b1;
            sclk_oe_q <= 1'b0;
            rfs_oe_q  <= 1'b0;
            tx_word_q <= 16'h0000;
        end else begin
            burst_q   <= burst_d;
            div_cnt_q <= div_cnt_d;
            per_cnt_q <= per_cnt_d;
            sclk_q    <= sclk_d;
            rfs_o_q   <= rfs_o_d;
            sclk_oe_q <= mode_s2;
            rfs_oe_q  <= mode_s2;
            tx_word_q <= tx_word_d;
        end
    end

    // Link domain reset, clk_link must tick during srst
    logic lrst_s1, lrst_q;
    always_ff @(posedge clk_link) begin
        lrst_s1 <= srst;
        lrst_q  <= lrst_s1;
    end

    // Read shifter: bit launched on each rising serial edge
    logic [4:0] rd_cnt_q, rd_cnt_d;
    logic       dout_q, dout_d;
    logic       dout_oe_q, dout_oe_d;
    logic [3:0] rd_idx;
    assign rd_idx = 4'hf - rd_cnt_q[3:0];

    always_comb begin
        rd_cnt_d  = rd_cnt_q;
        dout_d    = 1'b0;
        dout_oe_d = 1'b0;
        if (read_frame_sync_n_i) begin
            rd_cnt_d = 5'h00;
        end else if (rd_cnt_q < BIT_CNT_MAX) begin
            // tx_word_q is held still for the whole frame
            dout_d    = tx_word_q[rd_idx];
            dout_oe_d = 1'b1;
            rd_cnt_d  = rd_cnt_q + 5'h01;
        end
    end

    // Sync high clears at once, since a host clock may park between frames
    always_ff @(posedge clk_link or posedge read_frame_sync_n_i) begin
        if (read_frame_sync_n_i) begin
            rd_cnt_q  <= 5'h00;
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end else if (lrst_q) begin
            rd_cnt_q  <= 5'h00;
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end else begin
            rd_cnt_q  <= rd_cnt_d;
            dout_q    <= dout_d;
            dout_oe_q <= dout_oe_d;
        end
    end

    // Write shifter on falling serial edge, runs beside the read
    logic [4:0] wr_cnt_q, wr_cnt_d;
    logic [4:0] wr_sh_q, wr_sh_d;
    logic [4:0] ctrl_lk_d;
    logic       ctrl_tgl_d;

    always_comb begin
        wr_cnt_d   = wr_cnt_q;
        wr_sh_d    = wr_sh_q;
        ctrl_lk_d  = ctrl_lk_q;
        ctrl_tgl_d = ctrl_tgl_q;
        if (write_frame_sync_n) begin
            wr_cnt_d = 5'h00;
        end else if (wr_cnt_q < BIT_CNT_MAX) begin
            wr_cnt_d = wr_cnt_q + 5'h01;
            if (wr_cnt_q < CMD_EDGE_IDX) begin
                wr_sh_d = {wr_sh_q[3:0], data_in};
            end
            // Remaining eleven bits are clocked but ignored
            if (wr_cnt_q == CMD_EDGE_IDX) begin
                ctrl_lk_d  = wr_sh_q;
                ctrl_tgl_d = !ctrl_tgl_q;
            end
        end
    end

    // Counter and shifter cleared by sync high, parked clock or not
    always_ff @(negedge clk_link or posedge write_frame_sync_n) begin
        if (write_frame_sync_n) begin
            wr_cnt_q <= 5'h00;
            wr_sh_q  <= 5'h00;
        end else if (lrst_q) begin
            wr_cnt_q <= 5'h00;
            wr_sh_q  <= 5'h00;
        end else begin
            wr_cnt_q <= wr_cnt_d;
            wr_sh_q  <= wr_sh_d;
        end
    end

    // Latched control word survives the end of the frame
    always_ff @(negedge clk_link) begin
        if (lrst_q) begin
            ctrl_lk_q  <= CTRL_RST;
            ctrl_tgl_q <= 1'b0;
        end else begin
            ctrl_lk_q  <= ctrl_lk_d;
            ctrl_tgl_q <= ctrl_tgl_d;
        end
    end

    // Outputs straight from flops
    assign sclk_o               = sclk_q;
    assign sclk_oe              = sclk_oe_q;
    assign read_frame_sync_n_o  = rfs_o_q;
    assign read_frame_sync_n_oe = rfs_oe_q;
    assign data_out_o           = dout_q;
    assign data_out_oe          = dout_oe_q;
    assign trial_code           = sar_q;
    assign mux_chan             = mux_chan_q;
    assign standby              = standby_q;
    assign conv_busy            = conv_busy_q;

    // Helper: cycles spent with the driven read sync low
    logic [15:0] low_cnt_q;
    always_ff @(posedge clk_sys) begin
        if (srst || rfs_o_q) begin
            low_cnt_q <= 16'h0000;
        end else begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    sequence s_result_ready;
        (burst_q == BURST_IDLE) && mode_s2 && fifo_out_valid;
    endsequence

    sequence s_burst_to_frame;
        (burst_q == BURST_LEAD) ##[1:64] (burst_q == BURST_FRAME);
    endsequence

    a_self_master: assert property (@(posedge clk_sys) disable iff (srst)
        (burst_q == BURST_FRAME) |-> (rfs_oe_q && sclk_oe_q && !rfs_o_q))
        else $error("frame without device-driven clock and sync");
    a_sclk_derived: assert property (@(posedge clk_sys) disable iff (srst)
        ((burst_q != BURST_IDLE) && tick) |=> (sclk_q != $past(sclk_q)))
        else $error("serial clock missed a divider tick");
    a_auto_send: assert property (@(posedge clk_sys) disable iff (srst)
        s_result_ready |=> s_burst_to_frame)
        else $error("queued result did not start a frame");
    a_frame_len: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(rfs_o_q) |-> (low_cnt_q == FRAME_CYC))
        else $error("driven frame not sixteen serial periods");
    a_link_count: assert property (@(posedge clk_link) disable iff (lrst_q)
        (!read_frame_sync_n_i && (rd_cnt_q == BIT_CNT_MAX)) |=> !dout_oe_q)
        else $error("more than sixteen bits driven");
    a_tied_write: assert property (@(negedge clk_link) disable iff (lrst_q)
        (!write_frame_sync_n && !read_frame_sync_n_i && (wr_cnt_q < CMD_EDGE_IDX))
        |=> (wr_sh_q[0] == $past(data_in)))
        else $error("input bit not shifted during read frame");
    a_ctrl_accept: assert property (@(posedge clk_sys) disable iff (srst)
        ctrl_evt |=> (mux_chan_q == $past(ctrl_lk_q[4:2])))
        else $error("control write not taken");
    a_decide_fall: assert property (@(negedge clk_sys) disable iff (srst)
        (conv_busy_q && (step_q != 4'h0))
        |=> ((step_q == $past(step_q) - 4'h1) && sar_q[step_q]))
        else $error("bit decision out of step");
    a_launch_rise: assert property (@(negedge clk_link) disable iff (lrst_q)
        (!read_frame_sync_n_i && (rd_cnt_q != 5'h00))
        |-> (dout_oe_q && (dout_q == tx_word_q[4'(5'h10 - rd_cnt_q)])))
        else $error("wrong bit launched");
    a_cmd_sixth: assert property (@(negedge clk_link) disable iff (lrst_q)
        (!write_frame_sync_n && (wr_cnt_q == CMD_EDGE_IDX))
        |=> (ctrl_tgl_q != $past(ctrl_tgl_q)) ##1 $stable(ctrl_tgl_q))
        else $error("command not latched on sixth edge");
    a_idle_quiet: assert property (@(posedge clk_link) disable iff (lrst_q)
        read_frame_sync_n_i |=> (!dout_oe_q && (rd_cnt_q == 5'h00)))
        else $error("output driven outside frame");
endmodule

// [tb/asfi_host_model.sv]
`timescale 1ns/1ps
// Host serial port, 16-bit frames, syncs tied, reads on falling edge
module asfi_host_model (
    input  wire logic        run_clk,   // Free clock wanted, reset only
    input  wire logic        clk_link,  // Resolved serial clock wire
    input  wire logic        fs_n,      // Resolved read sync wire
    input  wire logic        dout,      // Device result line
    input  wire logic [15:0] tx_word,   // Next control word
    input  wire logic        go,        // Start a host-clocked frame
    output logic             host_clk,
    output logic             host_fs_n,
    output logic             data_in,
    output logic [15:0]      rx_word,
    output logic             rx_done
);
    logic [4:0]  cnt_q = 5'h00;   // Bits taken this frame
    logic [15:0] sh_q  = 16'h0000; // Receive shifter
    logic        in_q  = 1'b0;    // Frame seen on rising edge
    initial begin
        host_clk = 1'b0;
        host_fs_n = 1'b1;
        data_in = 1'b0;
        rx_word = 16'h0000;
        rx_done = 1'b0;
    end
    // Clock runs in reset and frames, else parks low
    always #15 if (run_clk || !host_fs_n || host_clk) host_clk = ~host_clk;
    // Host-clocked frame, sync low for sixteen periods
    always @(posedge go) begin
        #1;
        host_fs_n = 1'b0;
        repeat (16) @(negedge host_clk);
        host_fs_n = 1'b1;
    end
    // Control bits launched on rising edge, MSB first
    always @(posedge clk_link) begin
        in_q <= !fs_n;
        if (!fs_n) begin
            data_in <= tx_word[5'h0f - cnt_q];
        end else begin
            data_in <= ~data_in; // Released line keeps moving
        end
    end
    // Sync sampled mid-period avoids racing the sync edge
    always @(negedge clk_link) begin
        rx_done <= 1'b0;
        if (in_q) begin
            sh_q  <= {sh_q[14:0], dout};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h0f) begin
                rx_word <= {sh_q[14:0], dout};
                rx_done <= 1'b1;
                cnt_q   <= 5'h00;
            end
        end
    end
endmodule

// [tb/asfi_top_test.sv]
`timescale 1ns/1ps
module asfi_top_test;
    import asfi_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic        mode    = 1'b1;     // Self-clocking first
    logic        start_n = 1'b1;
    logic        go      = 1'b0;
    logic        lrun    = 1'b1;     // Link clock runs over reset and release
    logic [15:0] tx_word = 16'h0000;
    logic [11:0] target  = 12'h000;  // Analog level being converted
    logic [15:0] rnd     = 16'h0028; // LFSR seed
    logic [2:0]  cur;
    logic [2:0]  nxt;
    int          err_count   = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [15:0] exp_q[$];           // Expected result words
    logic sclk_o, sclk_oe, rfs_o, rfs_oe, dout_o, dout_oe, standby, conv_busy;
    logic host_clk, host_fs_n, data_in, rx_done;
    logic [11:0] trial_code;
    logic [2:0]  mux_chan;
    logic [15:0] rx_word;
    // Wire resolution from the device's enables and the mode strap
    wire clk_link = sclk_oe ? sclk_o : host_clk;
    // Board delay keeps the syncs off the serial clock edges
    wire #2 fs_n  = rfs_oe ? rfs_o : host_fs_n;
    wire #2 wfs_n = mode ? rfs_o : host_fs_n;
    wire dwire    = dout_oe ? dout_o : ~dout_o;
    wire cmp_hi   = target >= trial_code; // Comparator keeps trial bit
    always #5 clk_sys = ~clk_sys;
    asfi_top u_dut (
        .clk_sys(clk_sys), .srst(srst), .self_clock_mode(mode),
        .conversion_start_n(start_n), .cmp_hi(cmp_hi), .clk_link(clk_link),
        .read_frame_sync_n_i(fs_n), .write_frame_sync_n(wfs_n), .data_in(data_in),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .read_frame_sync_n_o(rfs_o),
        .read_frame_sync_n_oe(rfs_oe), .data_out_o(dout_o), .data_out_oe(dout_oe),
        .trial_code(trial_code), .mux_chan(mux_chan), .standby(standby),
        .conv_busy(conv_busy));
    asfi_host_model u_host (
        .run_clk(lrun), .clk_link(clk_link), .fs_n(fs_n), .dout(dwire),
        .tx_word(tx_word), .go(go), .host_clk(host_clk), .host_fs_n(host_fs_n),
        .data_in(data_in), .rx_word(rx_word), .rx_done(rx_done));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, a few hundred cycles of real work expected
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    // A received word is matched against the oldest note while any note is queued
    always @(posedge rx_done) begin
        if (exp_q.size() != 0) begin
            chk(rx_word, exp_q.pop_front(), "result word");
        end
    end
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (conv_busy !== lvl && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk({15'h0000, conv_busy}, {15'h0000, lvl}, "busy");
    endtask
    // Hardware start pulse; code must settle on the target
    task automatic start_conv(input logic [2:0] ch, input logic push);
        rnd = lfsr(rnd);
        @(posedge clk_sys);
        target  <= rnd[11:0];
        start_n <= 1'b0;
        if (push) begin
            exp_q.push_back({1'b0, ch, rnd[11:0]});
        end
        repeat (4) @(posedge clk_sys);
        start_n <= 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk({4'h0, trial_code}, {4'h0, target}, "final code");
    endtask
    task automatic frame(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge clk_sys);
        tx_word <= w;
        go      <= 1'b1;
        @(posedge clk_sys);
        go      <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (host_fs_n !== 1'b1 && n < 100);
    endtask
    task automatic do_reset(input logic m);
        srst <= 1'b1;
        lrun <= 1'b1;
        mode <= m;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        lrun <= 1'b0;
    endtask
    initial begin
        int n;
        do_reset(1'b1);
        // Self-clocked: results arrive unasked, control word rides along
        cur = 3'h0;
        for (int i = 0; i < 3; i++) begin
            nxt = 3'(lfsr(rnd) >> 13);
            tx_word <= {nxt, 13'h0000};
            start_conv(cur, 1'b1);
            n = 0;
            while (exp_q.size() != 0 && n < 300) begin
                @(posedge clk_sys);
                n++;
            end
            chk({15'h0000, sclk_oe}, 16'h0001, "clock master");
            chk({13'h0000, mux_chan}, {13'h0000, nxt}, "channel");
            chk(16'(exp_q.size()), 16'h0000, "words left");
            cur = nxt;
        end
        $display("self-clock test done");
        // Host-clocked: software start, read after conversion
        do_reset(1'b0);
        rnd = lfsr(rnd);
        target <= rnd[11:0];
        frame({3'h5, 2'b10, 11'h000});
        wait_busy(1'b0);
        chk({4'h0, trial_code}, {4'h0, target}, "soft start code");
        exp_q.push_back({4'h5, target});
        repeat (10) @(posedge clk_sys);
        frame({3'h5, 13'h0000});
        chk(16'(exp_q.size()), 16'h0000, "words left");
        // Write overlapping a conversion, then read its result
        // Read opens before the start edge, never just after it
        fork
            frame({3'h2, 13'h0000});
            start_conv(3'h5, 1'b0);
        join
        chk({13'h0000, mux_chan}, 16'h0002, "channel in conversion");
        exp_q.push_back({4'h5, target});
        repeat (10) @(posedge clk_sys);
        frame({3'h2, 2'b01, 11'h000});
        chk(16'(exp_q.size()), 16'h0000, "words left");
        chk({15'h0000, standby}, 16'h0001, "standby");
        $display("external-clock test done");
        end_of_test();
    end
endmodule
